// *** rtl/dps_panel_seq.sv ***
// Front-panel and start-up sequencer with APB status and history
//
// Behaviour
// - Start needs AC, door latched, cartridge present
// - No spindle start while fault is showing
// - Ready lamp steady once heads loaded and media tests passed
// - Ready blinks during spin up and down
// - Ready lit while on cylinder despite fault
// - Ready blinks rapidly during drive activity
// - Latched guard switch inhibits fixed-disk writes
// - Guard lamp steady when protected, no fault
// - Guard lamp blinks normally on drive fault
// - Media fault: rapid lamp, ready held off
// - Door stays locked until spindle stopped
// - Door releases only with run switch out
// - AC loss keeps the door locked
// - Double press clears fault, shows history
// - History kept since most recent fault clear
// - Lock door before spinning, blink ready as spindle starts
// - Load heads, test rapidly, then ready steady
// - Successful clear returns ready to active
// - Five media retests, then fault unclearable
// - Media failures logged with cylinder bytes
// - Self test clears lamp within six seconds
`timescale 1ns/1ns
module dps_panel_seq
  import dps_pkg::*;
#(
  parameter int unsigned DEB_CYC_P    = DEB_CYC,
  parameter int unsigned NORM_HALF_P  = NORM_HALF_CYC,
  parameter int unsigned RAPID_HALF_P = RAPID_HALF_CYC,
  parameter int unsigned CLR_WIN_P    = CLR_WIN_CYC,
  parameter int unsigned DISP_STEP_P  = DISP_STEP_CYC,
  parameter int unsigned SELFTEST_P   = SELFTEST_CYC,
  parameter int unsigned HIST_P       = HIST_DEPTH
)(
  input  wire logic        pclk,           // System clock
  input  wire logic        presetn,        // Async reset, low
  input  wire logic        psel,           // APB select
  input  wire logic        penable,        // APB enable
  input  wire logic        pwrite,         // APB write
  input  wire logic [11:0] paddr,          // APB address
  input  wire logic [31:0] pwdata,         // APB write data
  output logic      [31:0] prdata,         // APB read data
  output logic             pready,         // APB ready
  output logic             pslverr,        // APB error
  input  wire logic        run_sw_in,      // Run switch, 1 = start
  input  wire logic        fixed_media_guard_switch, // 1 = latched in
  input  wire logic        ac_ok_in,       // AC power present
  input  wire logic        door_ok_in,     // Door closed and latched
  input  wire logic        cart_ok_in,     // Cartridge in place
  input  wire logic        at_speed,       // Spindle up to speed
  input  wire logic        spin_stopped,   // Spindle fully stopped
  input  wire logic        heads_loaded,   // Heads loaded
  input  wire logic        on_cylinder,    // Heads on cylinder
  input  wire logic        activity,       // Seek/read/write/test busy
  input  wire logic        drive_fault,    // Drive fault present
  input  wire logic        selftest_pass,  // Processor self test ok
  input  wire logic        media_quality_check_pass, // Tests done ok
  input  wire logic        media_quality_check_fail, // Failure pulse
  input  wire logic [1:0]  mq_head,        // 0 head0, 1 head1, 2 both
  input  wire logic [15:0] mq_cyl,         // First bad cylinder
  input  wire logic        stat_valid,     // Status code strobe
  input  wire logic [7:0]  stat_code,      // Status code
  output logic             spindle_en,     // Spindle motor on
  output logic             head_load,      // Load heads and run tests
  output logic             mq_retest,      // Retest request pulse
  output logic             door_lock,      // Interlock solenoid hold
  output logic             ready_lamp,     // Ready indicator
  output logic             guard_fault_lamp, // Protect/fault indicator
  output logic             write_inhibit,  // Fixed disk write inhibit
  output logic             fault_clear_req, // Fault clear pulse
  output logic             disp_valid,     // Status display active
  output logic      [7:0]  disp_code       // Displayed status code
);
  localparam int unsigned HW = $clog2(HIST_P);
  localparam logic [HW:0] HFULL = (HW+1)'(HIST_P);

  // Parameter sanity
  if (RAPID_HALF_P >= NORM_HALF_P || RAPID_HALF_P == 0)
    $error("rapid blink must be shorter than normal");
  if (HIST_P < 2 || (1 << HW) != HIST_P)
    $error("history depth must be a power of two");

  typedef struct packed {
    logic [NPIN-1:0]         s1;
    logic [NPIN-1:0]         s2;
    logic [NPIN-1:0]         s3;
    logic [NPIN-1:0]         deb;
    logic [NPIN-1:0][31:0]   dcnt;
    logic [31:0]             bn_cnt;
    logic [31:0]             br_cnt;
    logic [31:0]             win_cnt;
    logic [31:0]             disp_tmr;
    logic [31:0]             st_cnt;
    logic                    bn;
    logic                    br;
    logic                    win;
    logic                    st_ok;
    logic                    st_fail;
    logic                    flt;
    logic                    mq_flt;
    logic [2:0]              retry;
    logic [1:0]              mq_pend;
    logic [15:0]             cyl;
    dps_state_t              st;
    logic                    lock;
    logic                    spin;
    logic                    load;
    logic                    rdy_l;
    logic                    flt_l;
    logic                    wi;
    logic                    clr_req;
    logic                    retest;
    logic                    disp_v;
    logic [7:0]              disp_code;
    logic [HW-1:0]           wp;
    logic [HW-1:0]           rd;
    logic [HW:0]             cnt;
    logic [HW:0]             left;
    logic [HIST_P-1:0][7:0]  hist;
    logic                    pready;
    logic                    pslverr;
    logic [31:0]             prdata;
  } dps_reg_t;

  dps_reg_t r_ff;
  dps_reg_t nxt_r;

  logic       press;
  logic       panel_clr;
  logic       host_clr;
  logic       clr;
  logic       acc;
  logic       done;
  logic       fault_any;
  logic       ok_start;
  logic       run_off;
  logic       wr;
  logic [7:0] wcode;

  always_comb
  begin
    nxt_r = r_ff;
    // Three-stage pin synchroniser, then debounce
    nxt_r.s1 = {cart_ok_in, door_ok_in, ac_ok_in,
                fixed_media_guard_switch, run_sw_in};
    nxt_r.s2 = r_ff.s1;
    nxt_r.s3 = r_ff.s2;
    for (int i = 0; i < NPIN; i++)
    begin
      if (r_ff.s2[i] == r_ff.s3[i] && r_ff.s3[i] != r_ff.deb[i])
      begin
        if (r_ff.dcnt[i] >= DEB_CYC_P - 1)
        begin
          nxt_r.deb[i]  = r_ff.s3[i];
          nxt_r.dcnt[i] = '0;
        end
        else
          nxt_r.dcnt[i] = r_ff.dcnt[i] + 32'h1;
      end
      else
        nxt_r.dcnt[i] = '0;
    end

    // Free-running blink phases
    if (r_ff.bn_cnt >= NORM_HALF_P - 1)
    begin
      nxt_r.bn_cnt = '0;
      nxt_r.bn     = ~r_ff.bn;
    end
    else
      nxt_r.bn_cnt = r_ff.bn_cnt + 32'h1;
    if (r_ff.br_cnt >= RAPID_HALF_P - 1)
    begin
      nxt_r.br_cnt = '0;
      nxt_r.br     = ~r_ff.br;
    end
    else
      nxt_r.br_cnt = r_ff.br_cnt + 32'h1;

    // Power-on self test window
    if (!r_ff.st_ok && !r_ff.st_fail)
    begin
      if (selftest_pass)
        nxt_r.st_ok = 1'b1;
      else if (r_ff.st_cnt >= SELFTEST_P - 1)
        nxt_r.st_fail = 1'b1;
      else
        nxt_r.st_cnt = r_ff.st_cnt + 32'h1;
    end

    // Alternate-action switch: every debounced change is a press
    press     = nxt_r.deb[PIN_GUARD] != r_ff.deb[PIN_GUARD];
    panel_clr = 1'b0;
    if (r_ff.win)
    begin
      if (press)
      begin
        nxt_r.win = 1'b0;
        panel_clr = 1'b1;
      end
      else if (r_ff.win_cnt >= CLR_WIN_P - 1)
        nxt_r.win = 1'b0;
      else
        nxt_r.win_cnt = r_ff.win_cnt + 32'h1;
    end
    else if (press)
    begin
      nxt_r.win     = 1'b1;
      nxt_r.win_cnt = '0;
    end

    // APB slave: one wait state, act when pready is seen
    acc           = psel && penable;
    done          = acc && r_ff.pready;
    nxt_r.pready  = acc && !r_ff.pready;
    nxt_r.pslverr = 1'b0;
    if (acc && !r_ff.pready)
    begin
      nxt_r.prdata = '0;
      case (paddr)
        ADDR_CTRL:   nxt_r.prdata = '0;
        ADDR_STATUS: nxt_r.prdata = {16'h0, 1'b0, r_ff.st, r_ff.retry,
                       r_ff.flt, r_ff.mq_flt, r_ff.st_ok, r_ff.st_fail,
                       r_ff.lock, r_ff.spin, r_ff.wi,
                       r_ff.rdy_l, r_ff.flt_l};
        ADDR_HIST:   nxt_r.prdata = {16'h0, 3'h0, 5'(r_ff.cnt),
                       r_ff.hist[r_ff.wp - 1'b1]};
        default:     nxt_r.pslverr = 1'b1;
      endcase
    end
    host_clr = done && pwrite && paddr == ADDR_CTRL
               && pwdata[CTRL_CLR_BIT];
    clr = panel_clr || host_clr;

    // Fault flag: a fault present in the clear cycle survives it
    nxt_r.clr_req = clr;
    nxt_r.retest  = 1'b0;
    nxt_r.flt     = drive_fault || (r_ff.flt && !clr);
    if (clr && r_ff.mq_flt && r_ff.retry < MQ_RETRY_MAX)
    begin
      nxt_r.mq_flt = 1'b0;
      nxt_r.retry  = r_ff.retry + 3'h1;
      nxt_r.retest = 1'b1;
    end
    if (media_quality_check_fail)
      nxt_r.mq_flt = 1'b1;

    // Status display steps through the captured codes
    if (r_ff.left != '0 || r_ff.disp_v)
    begin
      if (r_ff.disp_tmr >= DISP_STEP_P - 1)
      begin
        nxt_r.disp_tmr = '0;
        if (r_ff.left != '0)
        begin
          nxt_r.disp_v    = 1'b1;
          nxt_r.disp_code = r_ff.hist[r_ff.rd];
          nxt_r.rd        = r_ff.rd + 1'b1;
          nxt_r.left      = r_ff.left - 1'b1;
        end
        else
          nxt_r.disp_v = 1'b0;
      end
      else
        nxt_r.disp_tmr = r_ff.disp_tmr + 32'h1;
    end

    // Any clear restarts the history; panel clear shows the old one
    if (clr)
    begin
      nxt_r.cnt = '0;
      if (panel_clr)
      begin
        nxt_r.left     = r_ff.cnt;
        nxt_r.rd       = r_ff.wp - r_ff.cnt[HW-1:0];
        nxt_r.disp_tmr = '0;
      end
    end

    // Logging; a media failure takes three consecutive slots
    wr    = 1'b0;
    wcode = '0;
    if (media_quality_check_fail)
    begin
      wr = 1'b1;
      if (r_ff.retry >= MQ_RETRY_MAX)
        wcode = CODE_MQ_LAST;
      else if (mq_head == MQ_BOTH_SEL)
        wcode = CODE_MQ_BOTH;
      else if (mq_head == MQ_HEAD1_SEL)
        wcode = CODE_MQ_HEAD1;
      else
        wcode = CODE_MQ_HEAD0;
      nxt_r.mq_pend = 2'h2;
      nxt_r.cyl     = mq_cyl;
    end
    else if (r_ff.mq_pend != 2'h0)
    begin
      wr = 1'b1;
      wcode = (r_ff.mq_pend == 2'h2) ? r_ff.cyl[15:8] : r_ff.cyl[7:0];
      nxt_r.mq_pend = r_ff.mq_pend - 2'h1;
    end
    else if (stat_valid)
    begin
      wr    = 1'b1;
      wcode = stat_code;
    end
    if (wr)
    begin
      nxt_r.hist[r_ff.wp] = wcode;
      nxt_r.wp = r_ff.wp + 1'b1;
      if (nxt_r.cnt < HFULL)
        nxt_r.cnt = nxt_r.cnt + 1'b1;
    end

    // Spindle sequence
    fault_any = r_ff.flt || r_ff.mq_flt || r_ff.st_fail;
    ok_start  = r_ff.deb[PIN_RUN] && r_ff.deb[PIN_AC]
                && r_ff.deb[PIN_DOOR] && r_ff.deb[PIN_CART];
    run_off   = !r_ff.deb[PIN_RUN] || !r_ff.deb[PIN_AC]
                || !r_ff.deb[PIN_DOOR];
    case (r_ff.st)
      ST_IDLE:
        // Wait for the held door so the spindle never leads the lock
        if (ok_start && !fault_any && r_ff.lock)
          nxt_r.st = ST_SPINUP;
      ST_SPINUP:
        if (run_off)
          nxt_r.st = ST_SPINDOWN;
        else if (at_speed)
          nxt_r.st = ST_LOADING;
      ST_LOADING:
        if (run_off)
          nxt_r.st = ST_SPINDOWN;
        else if (media_quality_check_pass && heads_loaded
                 && !r_ff.mq_flt)
          nxt_r.st = ST_READY;
      ST_READY:
        if (run_off)
          nxt_r.st = ST_SPINDOWN;
        else if (nxt_r.retest)
          nxt_r.st = ST_LOADING;
      ST_SPINDOWN:
        if (spin_stopped)
          nxt_r.st = ST_IDLE;
      default:
        nxt_r.st = ST_IDLE;
    endcase

    // Solenoid only lets go when stopped, run out and AC present
    nxt_r.lock = !(r_ff.st == ST_IDLE && spin_stopped
                   && !r_ff.deb[PIN_RUN] && r_ff.deb[PIN_AC]);
    // Spindle follows the lock by a cycle so the door is held first
    nxt_r.spin = r_ff.lock && (r_ff.st == ST_SPINUP
                 || r_ff.st == ST_LOADING || r_ff.st == ST_READY);
    nxt_r.load = r_ff.st == ST_LOADING || r_ff.st == ST_READY;
    nxt_r.wi   = r_ff.deb[PIN_GUARD];

    // Ready lamp
    if (r_ff.mq_flt)
      nxt_r.rdy_l = 1'b0;
    else if (r_ff.st == ST_SPINUP || r_ff.st == ST_SPINDOWN)
      nxt_r.rdy_l = r_ff.bn;
    else if (r_ff.st == ST_LOADING)
      nxt_r.rdy_l = r_ff.br;
    else if (r_ff.st == ST_READY && activity)
      nxt_r.rdy_l = r_ff.br;
    else if (r_ff.st == ST_READY)
      nxt_r.rdy_l = heads_loaded || on_cylinder;
    else
      nxt_r.rdy_l = 1'b0;

    // Guard/fault lamp
    if (r_ff.mq_flt)
      nxt_r.flt_l = r_ff.br;
    else if (r_ff.flt)
      nxt_r.flt_l = r_ff.bn;
    else if (!r_ff.st_ok)
      nxt_r.flt_l = 1'b1;
    else
      nxt_r.flt_l = r_ff.deb[PIN_GUARD];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r_ff       <= '0;
      r_ff.lock  <= 1'b1;
      r_ff.flt_l <= 1'b1;
    end
    else
      r_ff <= nxt_r;
  end

  assign prdata           = r_ff.prdata;
  assign pready           = r_ff.pready;
  assign pslverr          = r_ff.pslverr;
  assign spindle_en       = r_ff.spin;
  assign head_load        = r_ff.load;
  assign mq_retest        = r_ff.retest;
  assign door_lock        = r_ff.lock;
  assign ready_lamp       = r_ff.rdy_l;
  assign guard_fault_lamp = r_ff.flt_l;
  assign write_inhibit    = r_ff.wi;
  assign fault_clear_req  = r_ff.clr_req;
  assign disp_valid       = r_ff.disp_v;
  assign disp_code        = r_ff.disp_code;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  start_gate_a: assert property (
    r_ff.st == ST_IDLE ##1 r_ff.st == ST_SPINUP |->
      $past(r_ff.deb[PIN_AC]) && $past(r_ff.deb[PIN_DOOR])
      && $past(r_ff.deb[PIN_CART])) else $error("start without interlocks");
  start_fault_a: assert property (
    r_ff.st == ST_IDLE && (r_ff.flt || r_ff.mq_flt) |=>
      r_ff.st == ST_IDLE) else $error("start during fault");
  lock_first_a: assert property (
    $rose(r_ff.spin) |-> $past(r_ff.lock, 2)) else $error("spin before lock");
  door_hold_a: assert property (
    !spin_stopped |=> r_ff.lock) else $error("door freed while turning");
  door_run_a: assert property (
    r_ff.deb[PIN_RUN] |=> r_ff.lock) else $error("door freed at start");
  door_ac_a: assert property (
    !r_ff.deb[PIN_AC] |=> r_ff.lock) else $error("door freed without AC");
  mq_ready_a: assert property (
    r_ff.mq_flt |=> !r_ff.rdy_l) else $error("ready lit on media fault");
  inhibit_a: assert property (
    r_ff.deb[PIN_GUARD] |=> r_ff.wi) else $error("write not inhibited");
  retry_cap_a: assert property (
    r_ff.retry == MQ_RETRY_MAX && r_ff.mq_flt |=> r_ff.mq_flt)
    else $error("media fault cleared past limit");
  mq_log_a: assert property (
    media_quality_check_fail |=> r_ff.mq_pend == 2'h2 ##1
      r_ff.mq_pend == 2'h1 ##1 r_ff.mq_pend == 2'h0)
    else $error("cylinder bytes not logged");
  selftest_a: assert property (
    !r_ff.st_ok && !r_ff.flt && !r_ff.mq_flt |=> r_ff.flt_l)
    else $error("lamp cleared before self test");

  ready_c: cover property (r_ff.st == ST_READY && r_ff.rdy_l);
  panel_clr_c: cover property (panel_clr && r_ff.mq_flt);
  retry_max_c: cover property (r_ff.mq_flt && r_ff.retry == MQ_RETRY_MAX);
  display_c: cover property (r_ff.disp_v && r_ff.left == '0);
endmodule

// *** rtl/dps_pkg.sv ***
// Constants and types for the disk panel sequencer
package dps_pkg;
  // Clock and timing figures
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned CYC_PER_MS     = CLK_HZ / 1000;
  localparam int unsigned SELFTEST_MS    = 6000;
  localparam int unsigned SELFTEST_CYC   = SELFTEST_MS * CYC_PER_MS;
  localparam int unsigned DEB_MS         = 10;
  localparam int unsigned DEB_CYC        = DEB_MS * CYC_PER_MS;
  localparam int unsigned BLINK_NORM_MS  = 500;
  localparam int unsigned NORM_HALF_CYC  = BLINK_NORM_MS * CYC_PER_MS / 2;
  localparam int unsigned BLINK_RAPID_MS = 125;
  localparam int unsigned RAPID_HALF_CYC = BLINK_RAPID_MS * CYC_PER_MS / 2;
  localparam int unsigned CLR_WIN_MS     = 1000;
  localparam int unsigned CLR_WIN_CYC    = CLR_WIN_MS * CYC_PER_MS;
  localparam int unsigned DISP_STEP_MS   = 1000;
  localparam int unsigned DISP_STEP_CYC  = DISP_STEP_MS * CYC_PER_MS;

  // History and retest limits
  localparam int unsigned HIST_DEPTH    = 16;
  localparam logic [2:0]  MQ_RETRY_MAX  = 3'h5;

  // Media quality status codes
  localparam logic [7:0] CODE_MQ_HEAD0 = 8'h8A;
  localparam logic [7:0] CODE_MQ_HEAD1 = 8'h88;
  localparam logic [7:0] CODE_MQ_BOTH  = 8'h8C;
  localparam logic [7:0] CODE_MQ_LAST  = 8'h8D;
  localparam logic [1:0] MQ_HEAD1_SEL  = 2'h1;
  localparam logic [1:0] MQ_BOTH_SEL   = 2'h2;

  // Register byte offsets and fields
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_HIST   = 12'h008;
  localparam int unsigned CTRL_CLR_BIT = 0;

  // Synchronised pin indices
  localparam int unsigned PIN_RUN   = 0;
  localparam int unsigned PIN_GUARD = 1;
  localparam int unsigned PIN_AC    = 2;
  localparam int unsigned PIN_DOOR  = 3;
  localparam int unsigned PIN_CART  = 4;
  localparam int unsigned NPIN      = 5;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'h0,
    ST_SPINUP   = 3'h1,
    ST_LOADING  = 3'h3,
    ST_READY    = 3'h2,
    ST_SPINDOWN = 3'h6
  } dps_state_t;
endpackage

// *** verification/dps_mech_model.sv ***
// Behavioural spindle and head mechanics facing the sequencer
`timescale 1ns/1ns
module dps_mech_model #(
  parameter int SPIN_CYC = 40,  // Cycles from rest to full speed
  parameter int LOAD_CYC = 20   // Cycles from load start to tests done
)(
  input  wire logic pclk,         // System clock
  input  wire logic presetn,      // Async reset, low
  input  wire logic spindle_en,   // Motor drive
  input  wire logic head_load,    // Load and test request
  output logic      at_speed,     // Spindle at speed
  output logic      spin_stopped, // Spindle at rest
  output logic      heads_loaded, // Heads flying
  output logic      mq_pass       // Media tests passed
);
  int speed;
  int load;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      speed <= 0;
      load  <= 0;
    end
    else
    begin
      // Coasting down takes as long as spinning up
      if (spindle_en && speed < SPIN_CYC) speed <= speed + 1;
      else if (!spindle_en && speed > 0) speed <= speed - 1;
      if (!head_load || !at_speed) load <= 0;
      else if (load < LOAD_CYC) load <= load + 1;
    end
  assign at_speed     = (speed == SPIN_CYC);
  assign spin_stopped = (speed == 0);
  assign heads_loaded = (load >= 4);
  assign mq_pass      = (load == LOAD_CYC);
endmodule

// *** verification/tb_disk_panel_sequencer.sv ***
// Self-checking bench for the disk panel sequencer
`timescale 1ns/1ns
module tb_disk_panel_sequencer;
  import dps_pkg::*;
  localparam int DEB = 4, NH = 8, RH = 2, WIN = 64, STEP = 4, ST = 200;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        pready, pslverr, e;
  logic        run = 0, guard = 0, ac = 0, door = 0, cart = 0, act = 0;
  logic        dflt = 0, st_ok = 0, mq_fail = 0, st_v = 0;
  logic [1:0]  mq_head = 2'h0;
  logic [15:0] mq_cyl = 16'h0;
  logic [7:0]  st_code = 8'h0, disp_code;
  logic        at_spd, stopped, loaded, mq_ok, spin, hload, retest, lock;
  logic        rdy, flamp, inhibit, clr, disp_v;
  int          mismatches = 0, checked = 0, n_clr = 0, n_ret = 0, t, k;
  logic [7:0]  hist_q[$];

  always #5 pclk = ~pclk;

  dps_panel_seq #(.DEB_CYC_P(DEB), .NORM_HALF_P(NH), .RAPID_HALF_P(RH),
    .CLR_WIN_P(WIN), .DISP_STEP_P(STEP), .SELFTEST_P(ST),
    .HIST_P(HIST_DEPTH)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .run_sw_in(run),
    .fixed_media_guard_switch(guard), .ac_ok_in(ac), .door_ok_in(door),
    .cart_ok_in(cart), .at_speed(at_spd), .spin_stopped(stopped),
    .heads_loaded(loaded), .on_cylinder(loaded), .activity(act),
    .drive_fault(dflt), .selftest_pass(st_ok),
    .media_quality_check_pass(mq_ok), .media_quality_check_fail(mq_fail),
    .mq_head(mq_head), .mq_cyl(mq_cyl), .stat_valid(st_v),
    .stat_code(st_code), .spindle_en(spin), .head_load(hload),
    .mq_retest(retest), .door_lock(lock), .ready_lamp(rdy),
    .guard_fault_lamp(flamp), .write_inhibit(inhibit),
    .fault_clear_req(clr), .disp_valid(disp_v), .disp_code(disp_code));

  dps_mech_model MECH (.pclk(pclk), .presetn(presetn), .spindle_en(spin),
    .head_load(hload), .at_speed(at_spd), .spin_stopped(stopped),
    .heads_loaded(loaded), .mq_pass(mq_ok));

  always @(posedge pclk)
  begin
    if (clr === 1'b1) n_clr++;
    if (retest === 1'b1) n_ret++;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1);
    check(n, 2, "apb wait");
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Counts lamp changes; f selects the guard lamp
  task automatic tg(input bit f, input int n);
    logic p;
    p = f ? flamp : rdy;
    t = 0;
    repeat (n)
    begin
      @(posedge pclk);
      if ((f ? flamp : rdy) !== p) t++;
      p = f ? flamp : rdy;
    end
  endtask

  // Double press of the guard switch, then compare the shown codes
  task automatic panel_clear();
    guard <= 1'b0;
    cyc(20);
    guard <= 1'b1;
    for (int i = 0; i < 60 && disp_v !== 1'b1; i++) @(posedge pclk);
    check(disp_v, 1, "display on");
    foreach (hist_q[i])
    begin
      check(disp_code, hist_q[i], "displayed code");
      cyc(STEP);
    end
    hist_q.delete();
  endtask

  task automatic complete_run();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    cyc(20000);
    mismatches++;
    $display("BAD t=%0t watchdog expired", $time);
    complete_run();
  end

  initial
  begin
    void'($urandom(30));
    cyc(3);
    presetn <= 1'b1;
    st_ok <= 1'b1;
    @(posedge pclk);
    check(lock, 1, "lock at reset");
    cyc(ST + 10);
    check(flamp, 0, "self test lamp");
    $display("test power_up done");
    run <= 1'b1;
    ac <= 1'b1;
    door <= 1'b1;
    cyc(30);
    check(spin, 0, "start without cartridge");
    check(lock, 1, "lock with run in");
    dflt <= 1'b1;
    cart <= 1'b1;
    @(posedge pclk);
    dflt <= 1'b0;
    cyc(30);
    check(spin, 0, "start with fault");
    apb(1'b1, ADDR_CTRL, 32'h1);
    for (int i = 0; i < 100 && spin !== 1'b1; i++) @(posedge pclk);
    check(spin, 1, "spindle start");
    check(lock, 1, "lock before spin");
    tg(0, 16);
    check(t >= 2, 1, "spin up blink");
    $display("test start done");
    for (int i = 0; i < 200 && at_spd !== 1'b1; i++) @(posedge pclk);
    cyc(3);
    check(hload, 1, "heads loading");
    tg(0, 8);
    check(t, 4, "loading rapid blink");
    for (int i = 0; i < 100 && mq_ok !== 1'b1; i++) @(posedge pclk);
    cyc(5);
    tg(0, 32);
    check({t[7:0], rdy}, 9'h1, "ready steady");
    act <= 1'b1;
    cyc(3);
    tg(0, 16);
    check(t, 8, "activity rapid blink");
    act <= 1'b0;
    guard <= 1'b1;
    cyc(WIN + 20);
    check(inhibit, 1, "write inhibit");
    tg(1, 16);
    check({t[7:0], flamp}, 9'h1, "protect lamp steady");
    $display("test ready done");
    apb(1'b1, ADDR_CTRL, 32'h1);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge pclk);
      st_v <= 1'b1;
      st_code <= 8'($urandom);
      @(posedge pclk);
      hist_q.push_back(st_code);
      st_v <= 1'b0;
    end
    apb(1'b0, ADDR_HIST, 32'h0);
    check(r[12:0], {5'd3, hist_q[2]}, "history word");
    apb(1'b0, 12'h00C, 32'h0);
    check(r, 0, "unmapped read data");
    check(e, 1, "unmapped read error");
    dflt <= 1'b1;
    @(posedge pclk);
    dflt <= 1'b0;
    cyc(5);
    tg(1, 32);
    check(t, 4, "fault normal blink");
    check(rdy, 1, "ready on cylinder");
    panel_clear();
    check(n_clr, 3, "panel clear");
    tg(1, 16);
    check({t[7:0], flamp, rdy}, 10'h3, "after clear");
    $display("test fault_clear done");
    for (int i = 0; i < 6; i++)
    begin
      @(posedge pclk);
      mq_fail <= 1'b1;
      mq_head <= 2'(i % 3);
      mq_cyl <= 16'($urandom);
      @(posedge pclk);
      mq_fail <= 1'b0;
      hist_q.push_back(i == 5 ? CODE_MQ_LAST : i % 3 == 2 ? CODE_MQ_BOTH
                       : i % 3 == 1 ? CODE_MQ_HEAD1 : CODE_MQ_HEAD0);
      hist_q.push_back(mq_cyl[15:8]);
      hist_q.push_back(mq_cyl[7:0]);
      cyc(4);
      tg(1, 16);
      check({t[7:0], rdy}, 9'h10, "media fault lamps");
      apb(1'b0, ADDR_HIST, 32'h0);
      check(r[7:0], mq_cyl[7:0], "cylinder logged");
      if (i == 0) check(r[12:8], 3, "log entries");
      k = n_ret;
      if (i == 0)
      begin
        apb(1'b1, ADDR_CTRL, 32'h1);
        hist_q.delete();
      end
      else
        panel_clear();
      cyc(3);
      check(n_ret - k, i < 5, "retest pulse");
    end
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(r[11:9], MQ_RETRY_MAX, "retry count");
    tg(1, 16);
    check(t, 8, "fault unclearable");
    $display("test media done");
    run <= 1'b0;
    ac <= 1'b0;
    k = 0;
    for (int i = 0; i < 300 && stopped !== 1'b1; i++)
    begin
      @(posedge pclk);
      if (lock !== 1'b1) k++;
    end
    check(k, 0, "lock while turning");
    cyc(20);
    check(lock, 1, "lock without power");
    ac <= 1'b1;
    cyc(20);
    check(lock, 0, "door release");
    $display("test stop done");
    complete_run();
  end
endmodule
